//--- swb_defines.svh
// constants for the subtract-with-borrow execution block
// How it works
// RULE_01 - result is accumulator minus operand minus inverted carry
// RULE_02 - destination clear: result to accumulator, operand untouched
// RULE_03 - destination set (default): result written back to operand
// RULE_04 - access clear: fixed access bank, bank pointer ignored
// RULE_05 - access set (default): bank pointer joined with address
// RULE_06 - access clear, extended on, address up to 5Fh: indexed offset
// RULE_07 - flags N, OV, C, DC, Z updated; carry means no borrow
`ifndef SWB_DEFINES_SVH
`define SWB_DEFINES_SVH

// register port offsets
`define SWB_OFS_ACC       4'h0
`define SWB_OFS_FLAGS     4'h1
`define SWB_OFS_BANK      4'h2
`define SWB_OFS_CONFIG    4'h3
`define SWB_OFS_IDX_LO    4'h4
`define SWB_OFS_IDX_HI    4'h5
`define SWB_OFS_STATE     4'h6

// reset values
`define SWB_RST_ACC       8'h00
`define SWB_RST_FLAGS     5'h00
`define SWB_RST_BANK      4'h0
`define SWB_RST_IDX       12'h000
`define SWB_RST_ADDR      12'h000

// flag register bit positions
`define SWB_FLAG_C        0
`define SWB_FLAG_DC       1
`define SWB_FLAG_Z        2
`define SWB_FLAG_OV       3
`define SWB_FLAG_N        4

// access bank split and its high window
`define SWB_ACCESS_LAST   8'h5F
`define SWB_ACCESS_HIGH   4'hF

// config bit for the extended instruction set
`define SWB_CFG_EXT       0

`endif

//--- swb_pkg.sv
// types shared by the subtract-with-borrow execution block
package swb_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_CALC
    } exec_state_e;

    typedef struct packed {
        logic        n;
        logic        ov;
        logic        z;
        logic        dc;
        logic        c;
    } flags_s;

    typedef struct packed {
        logic [7:0]  f_addr;
        logic        dest;
        logic        access;
    } instr_s;

    typedef struct packed {
        exec_state_e state;
        instr_s      instr;
        logic [7:0]  acc;
        flags_s      flags;
        logic [3:0]  bank;
        logic        ext_en;
        logic [11:0] idx_base;
        logic [11:0] mem_addr;
        logic        mem_rd;
        logic        mem_wr;
        logic [7:0]  mem_wdata;
        logic        done;
        logic        busy;
        logic [7:0]  rd_data;
    } core_s;

endpackage

//--- swb_alu.sv
// subtract with borrow and its status flags
`timescale 1ns/100ps
`include "swb_defines.svh"

module swb_alu #(
    parameter int WIDTH = 8
) (
    // operands
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    input  wire logic             carry_in,
    // answer
    output logic      [WIDTH-1:0] result,
    output swb_pkg::flags_s       flags
);

    logic [WIDTH:0] sum;
    logic [4:0]     low_sum;

    // adding the complement plus carry equals subtracting the inverted carry
    always_comb begin
        sum     = {1'b0, minuend} + {1'b0, ~subtrahend}
                  + {{WIDTH{1'b0}}, carry_in}; // RULE_01
        low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                  + {4'h0, carry_in};
        result  = sum[WIDTH-1:0];
        flags.c  = sum[WIDTH]; // RULE_07
        flags.dc = low_sum[4]; // RULE_07
        flags.z  = (sum[WIDTH-1:0] == '0); // RULE_07
        flags.n  = sum[WIDTH-1]; // RULE_07
        // overflow: operand signs differ and result sign left the minuend's
        flags.ov = (minuend[WIDTH-1] != subtrahend[WIDTH-1])
                   && (sum[WIDTH-1] != minuend[WIDTH-1]); // RULE_07
    end

endmodule

//--- swb_exec.sv
// execution of subtract-with-borrow on the core data path
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "swb_defines.svh"

module swb_exec (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // instruction from the decoder
    input  wire logic            exec_req,
    input  wire swb_pkg::instr_s exec_instr,
    output logic                 exec_done,
    output logic                 exec_busy,
    // data memory, read data one cycle after the read strobe
    output logic [11:0]          mem_addr,
    output logic                 mem_rd,
    output logic                 mem_wr,
    output logic [7:0]           mem_wdata,
    input  wire logic [7:0]      mem_rdata,
    // register port
    input  wire logic [3:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [7:0]           reg_rdata,
    // core state seen by the rest of the core
    output logic [7:0]           acc_out,
    output swb_pkg::flags_s      flags_out
);

    swb_pkg::core_s   cur_reg;
    swb_pkg::core_s   cur_next;
    logic [7:0]       alu_result;
    swb_pkg::flags_s  alu_flags;
    logic [11:0]      op_addr;

    swb_alu #(
        .WIDTH      (8)
    ) u_alu (
        .minuend    (cur_reg.acc),
        .subtrahend (mem_rdata),
        .carry_in   (cur_reg.flags.c),
        .result     (alu_result),
        .flags      (alu_flags)
    );

    // operand address for the instruction being accepted
    always_comb begin
        if (exec_instr.access) begin
            op_addr = {cur_reg.bank, exec_instr.f_addr}; // RULE_05
        end else if (cur_reg.ext_en
                     && exec_instr.f_addr <= `SWB_ACCESS_LAST) begin
            // indexed literal offset: base plus the literal, wraps in 4K
            op_addr = cur_reg.idx_base + {4'h0, exec_instr.f_addr}; // RULE_06
        end else if (exec_instr.f_addr <= `SWB_ACCESS_LAST) begin
            op_addr = {4'h0, exec_instr.f_addr}; // RULE_04
        end else begin
            op_addr = {`SWB_ACCESS_HIGH, exec_instr.f_addr}; // RULE_04
        end
    end

    always_comb begin
        cur_next        = cur_reg;
        cur_next.mem_rd = 1'b0;
        cur_next.mem_wr = 1'b0;
        cur_next.done   = 1'b0;

        // register writes from software
        if (reg_wr) begin
            if (reg_addr == `SWB_OFS_ACC) begin
                cur_next.acc = reg_wdata;
            end else if (reg_addr == `SWB_OFS_FLAGS) begin
                cur_next.flags = reg_wdata[4:0];
            end else if (reg_addr == `SWB_OFS_BANK) begin
                cur_next.bank = reg_wdata[3:0];
            end else if (reg_addr == `SWB_OFS_CONFIG) begin
                cur_next.ext_en = reg_wdata[`SWB_CFG_EXT];
            end else if (reg_addr == `SWB_OFS_IDX_LO) begin
                cur_next.idx_base[7:0] = reg_wdata;
            end else if (reg_addr == `SWB_OFS_IDX_HI) begin
                cur_next.idx_base[11:8] = reg_wdata[3:0];
            end
        end

        // register reads, answered in the following cycle only
        if (reg_rd) begin
            if (reg_addr == `SWB_OFS_ACC) begin
                cur_next.rd_data = cur_reg.acc;
            end else if (reg_addr == `SWB_OFS_FLAGS) begin
                cur_next.rd_data = {3'h0, cur_reg.flags};
            end else if (reg_addr == `SWB_OFS_BANK) begin
                cur_next.rd_data = {4'h0, cur_reg.bank};
            end else if (reg_addr == `SWB_OFS_CONFIG) begin
                cur_next.rd_data = {7'h00, cur_reg.ext_en};
            end else if (reg_addr == `SWB_OFS_IDX_LO) begin
                cur_next.rd_data = cur_reg.idx_base[7:0];
            end else if (reg_addr == `SWB_OFS_IDX_HI) begin
                cur_next.rd_data = {4'h0, cur_reg.idx_base[11:8]};
            end else if (reg_addr == `SWB_OFS_STATE) begin
                cur_next.rd_data = {6'h00,
                                    cur_reg.state == swb_pkg::ST_READ,
                                    cur_reg.state != swb_pkg::ST_IDLE};
            end else begin
                cur_next.rd_data = 8'h00;
            end
        end else begin
            cur_next.rd_data = 8'h00;
        end

        // instruction sequence: read operand, process, write destination
        case (cur_reg.state)
            swb_pkg::ST_IDLE: begin
                // requests made while busy are not taken
                if (exec_req) begin
                    cur_next.instr    = exec_instr;
                    cur_next.mem_addr = op_addr;
                    cur_next.mem_rd   = 1'b1;
                    cur_next.state    = swb_pkg::ST_READ;
                end
            end
            swb_pkg::ST_READ: begin
                // memory answers in the next cycle
                cur_next.state = swb_pkg::ST_CALC;
            end
            swb_pkg::ST_CALC: begin
                // instruction update overrides a same-cycle software write
                cur_next.flags = alu_flags; // RULE_07
                if (cur_reg.instr.dest) begin
                    cur_next.mem_wr    = 1'b1; // RULE_03
                    cur_next.mem_wdata = alu_result; // RULE_03
                end else begin
                    cur_next.acc = alu_result; // RULE_02
                end
                cur_next.done  = 1'b1;
                cur_next.state = swb_pkg::ST_IDLE;
            end
            default: begin
                cur_next.state = swb_pkg::ST_IDLE;
            end
        endcase
        // busy kept as its own flop so the port is a register output
        cur_next.busy = (cur_next.state != swb_pkg::ST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_reg.state     <= swb_pkg::ST_IDLE;
            cur_reg.instr     <= '0;
            cur_reg.acc       <= `SWB_RST_ACC;
            cur_reg.flags     <= `SWB_RST_FLAGS;
            cur_reg.bank      <= `SWB_RST_BANK;
            cur_reg.ext_en    <= 1'b0;
            cur_reg.idx_base  <= `SWB_RST_IDX;
            cur_reg.mem_addr  <= `SWB_RST_ADDR;
            cur_reg.mem_rd    <= 1'b0;
            cur_reg.mem_wr    <= 1'b0;
            cur_reg.mem_wdata <= 8'h00;
            cur_reg.done      <= 1'b0;
            cur_reg.busy      <= 1'b0;
            cur_reg.rd_data   <= 8'h00;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign exec_done = cur_reg.done;
    assign exec_busy = cur_reg.busy;
    assign mem_addr  = cur_reg.mem_addr;
    assign mem_rd    = cur_reg.mem_rd;
    assign mem_wr    = cur_reg.mem_wr;
    assign mem_wdata = cur_reg.mem_wdata;
    assign reg_rdata = cur_reg.rd_data;
    assign acc_out   = cur_reg.acc;
    assign flags_out = cur_reg.flags;

endmodule

//--- swb_exec_chk.sv
// concurrent checks on the ports of the subtract-with-borrow block
`timescale 1ns/100ps
module swb_exec_chk (
    // clock and reset
    input wire logic            clk,
    input wire logic            rst_b,
    // instruction side
    input wire logic            exec_req,
    input wire swb_pkg::instr_s exec_instr,
    input wire logic            exec_done,
    input wire logic            exec_busy,
    // data memory side
    input wire logic [11:0]     mem_addr,
    input wire logic            mem_rd,
    input wire logic            mem_wr,
    input wire logic [7:0]      mem_wdata,
    // software write strobe and core state
    input wire logic            reg_wr,
    input wire logic [7:0]      acc_out,
    input wire swb_pkg::flags_s flags_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence take_s;
        exec_req && !exec_busy;
    endsequence
    sequence high_pick_s;
        !exec_instr.access && exec_instr.f_addr > 8'h5F;
    endsequence
    chk_read_strobe: assert property (
        take_s |=> mem_rd && exec_busy)
        else $error("no operand read after request");
    chk_done_time: assert property (
        take_s |-> ##3 exec_done)
        else $error("done not three cycles after request");
    chk_busy_span: assert property (
        take_s |=> exec_busy[*2] ##1 !exec_busy)
        else $error("busy span wrong");
    chk_write_done: assert property (
        mem_wr |-> exec_done && $stable(mem_addr))
        else $error("write back not at done or address moved");
    chk_acc_kept: assert property (
        mem_wr && !$past(reg_wr) |-> $stable(acc_out))
        else $error("accumulator changed on write back");
    chk_high_window: assert property (
        take_s and high_pick_s
        |=> mem_addr == {4'hF, $past(exec_instr.f_addr)})
        else $error("access bank high window address wrong");
    chk_zero_flag: assert property (
        exec_done |-> flags_out.z ==
        ((mem_wr ? mem_wdata : acc_out) == 8'h00))
        else $error("zero flag disagrees with result");
    chk_sign_flag: assert property (
        exec_done |-> flags_out.n ==
        (mem_wr ? mem_wdata[7] : acc_out[7]))
        else $error("negative flag disagrees with result");
endmodule

//--- swb_mem_model.sv
// data memory seen by the execution block, one cycle read latency
`timescale 1ns/100ps
module swb_mem_model (
    // memory port
    input wire logic        clk,
    input wire logic [11:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    output logic [7:0]      mem_rdata
);
    logic [7:0] mem [4096];
    initial mem_rdata = 8'h00;
    // read data valid one cycle only; toggled otherwise so stale data shows
    always @(posedge clk) begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
        if (mem_rd)
            mem_rdata <= mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

//--- tb_subtract_with_borrow_exec.sv
// self-checking bench for the subtract-with-borrow block
`timescale 1ns/100ps
module tb_subtract_with_borrow_exec;
    logic            clk, rst_b, exec_req, exec_done, exec_busy;
    logic            mem_rd, mem_wr, reg_wr, reg_rd;
    swb_pkg::instr_s exec_instr;
    swb_pkg::flags_s flags_out;
    logic [11:0]     mem_addr;
    logic [7:0]      mem_wdata, mem_rdata, reg_wdata, reg_rdata, acc_out, rd_v;
    logic [3:0]      reg_addr;
    int              err_total = 0, total_checks = 0, tnum = 0;
    swb_exec dut_u (.clk, .rst_b, .exec_req, .exec_instr, .exec_done,
        .exec_busy, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_out,
        .flags_out);
    swb_mem_model mem_u (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
        .mem_rdata);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [11:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    // one instruction; expected result and flags worked out here, operand address given by the caller
    task automatic run(input logic [7:0] f, input logic d, a,
        input logic [11:0] ad, input logic [7:0] acc, op, input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, acc} + {1'b0, ~op} + 9'(cin);
        h = {1'b0, acc[3:0]} + {1'b0, ~op[3:0]} + 5'(cin);
        wr(4'h0, acc);
        wr(4'h1, {7'h00, cin});
        mem_u.mem[ad] = op;
        @(posedge clk);
        exec_req <= 1'b1;
        exec_instr <= '{f, d, a};
        for (int n = 0; n < 8 && exec_done !== 1'b1; n++) begin
            @(posedge clk);
            exec_req <= 1'b0;
            #1;
        end
        if (exec_done !== 1'b1) begin
            err_total++;
            conclude();
        end
        check("operand address", ad, mem_addr);
        rd(4'h0);
        check("accumulator", d ? acc : s[7:0], rd_v);
        check("operand", d ? s[7:0] : op, mem_u.mem[ad]);
        rd(4'h1);
        check("flags", {s[7], (acc[7] ^ op[7]) & (s[7] ^ acc[7]),
            s[7:0] == 8'h00, h[4], s[8]}, rd_v);
        rd(4'h6);
        check("state idle", 12'h000, rd_v);
        tnum++;
        $display("test %0d done", tnum);
    endtask
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    initial begin
        rst_b = 1'b0;
        exec_req = 1'b0;
        exec_instr = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0);
        check("acc reset", 12'h000, rd_v);
        rd(4'h1);
        check("flags reset", 12'h000, rd_v);
        rd(4'h7);
        check("unmapped read", 12'h000, rd_v);
        wr(4'h2, 8'h03);
        run(8'h10, 1'b1, 1'b1, 12'h310, 8'h02, 8'h03, 1'b1);
        run(8'h20, 1'b0, 1'b0, 12'h020, 8'h05, 8'h02, 1'b1);
        run(8'h60, 1'b1, 1'b0, 12'hF60, 8'h02, 8'h01, 1'b0);
        wr(4'h3, 8'h01);
        wr(4'h4, 8'hF0);
        wr(4'h5, 8'h0F);
        run(8'h5F, 1'b0, 1'b0, 12'h04F, 8'h80, 8'h01, 1'b1);
        run(8'h60, 1'b0, 1'b0, 12'hF60, 8'h7F, 8'hFF, 1'b0);
        run(8'h05, 1'b1, 1'b1, 12'h305, 8'h00, 8'h00, 1'b0);
        conclude();
    end
endmodule
bind swb_exec swb_exec_chk chk_u (.clk, .rst_b, .exec_req, .exec_instr,
    .exec_done, .exec_busy, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .reg_wr, .acc_out, .flags_out);
